/* hw/ccs_pkg.sv */
package ccs_pkg;
    // Register map
    localparam logic [15:0] CCS_CTRL_REG_ADDR = 16'hFFFB;
    localparam logic [7:0] CCS_CTRL_REG_RESET = 8'h04;
    localparam int CCS_BIT_OSC_STOP = 7;
    localparam int CCS_BIT_SRC_STAT = 5;
    localparam int CCS_BIT_SRC_SEL = 4;
    localparam int CCS_DIV_LSB = 0;
    localparam int CCS_DIV_W = 3;
    localparam logic [2:0] CCS_DIV_MAX = 3'h4;
    localparam logic [2:0] CCS_DIV_RESET = 3'h4;

    // Timing: main clock is modelled at the system clock rate
    localparam int CCS_SYS_FREQ_HZ = 20_000_000;
    localparam int CCS_STAB_EXP = 17;
    localparam int CCS_STAB_CYCLES = 2 ** CCS_STAB_EXP;
    localparam int CCS_SUB_FREQ_HZ = 40_000;
    localparam int CCS_SUB_DIV = CCS_SYS_FREQ_HZ / CCS_SUB_FREQ_HZ;
    localparam int CCS_SWITCH_TICKS = 16;

    // Controller register map on the user port
    localparam logic [3:0] CCS_H_REG_WR = 4'h0;
    localparam logic [3:0] CCS_H_BIT_WR = 4'h1;
    localparam logic [3:0] CCS_H_MODE = 4'h2;
    localparam logic [3:0] CCS_H_REG_RD = 4'h3;
    localparam logic [3:0] CCS_H_STATUS = 4'h4;
    localparam int CCS_MODE_EXT_MAIN = 0;
    localparam int CCS_MODE_CAN_EXT = 1;
    localparam int CCS_MODE_HALT = 2;
    localparam int CCS_MODE_STOP = 3;
    localparam logic [3:0] CCS_MODE_RESET = 4'h0;

    typedef enum logic [1:0] {
        CCS_SW_IDLE,
        CCS_SW_WAIT
    } ccs_sw_state_t;
endpackage : ccs_pkg

/* hw/ccs_if.sv */
`timescale 1ns/100ps
interface ccs_if;
    logic wr_byte;
    logic wr_bit;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [7:0] rdata;
    logic halt;
    logic stop;
    logic cpu_run;
    logic cpu_clk_en;

    modport dev (
        input wr_byte, wr_bit, rd, addr, wdata, bit_idx, bit_val, halt, stop,
        output rdata, cpu_run, cpu_clk_en
    );
    modport host (
        output wr_byte, wr_bit, rd, addr, wdata, bit_idx, bit_val, halt, stop,
        input rdata, cpu_run, cpu_clk_en
    );
endinterface : ccs_if

/* hw/ccs_clock_gen.sv */
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module ccs_clock_gen #(
    parameter int STAB_CYCLES = ccs_pkg::CCS_STAB_CYCLES,
    parameter int SUB_DIV = ccs_pkg::CCS_SUB_DIV,
    parameter int SWITCH_TICKS = ccs_pkg::CCS_SWITCH_TICKS
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // CPU side
    ccs_if.dev BUS,
    // Clock consumers
    output logic MAIN_OSC_RUN_O,
    output logic MAIN_CLK_EN_O,
    output logic SUB_CLK_EN_O,
    output logic CPU_CLK_EN_O,
    output logic WDT_EN_O,
    output logic CLK_SRC_SUB_O
);
    import ccs_pkg::*;

    // Divider code to mask of low counter bits that must all be one
    function automatic logic [3:0] div_mask(input logic [2:0] code);
        case (code)
            3'h0: div_mask = 4'h0;
            3'h1: div_mask = 4'h1;
            3'h2: div_mask = 4'h3;
            3'h3: div_mask = 4'h7;
            default: div_mask = 4'hF;
        endcase
    endfunction : div_mask

    // Software-visible fields
    logic main_osc_stop_q;
    logic clock_source_select_q;
    logic [2:0] cpu_divider_sel_q;
    // Settings in force
    logic clock_source_status_q;
    logic [2:0] act_div_q;
    ccs_sw_state_t sw_q;
    logic [4:0] sw_cnt_q;
    // Oscillators and dividers
    logic osc_run_q;
    logic [17:0] stab_cnt_q;
    logic main_ready_q;
    logic cpu_run_q;
    logic [15:0] sub_cnt_q;
    logic sub_half_q;
    logic [3:0] main_div_q;
    logic [7:0] rdata_q;

    wire hit = BUS.addr == CCS_CTRL_REG_ADDR;
    wire byte_wr = BUS.wr_byte & hit;
    wire bit_wr = BUS.wr_bit & hit;
    wire [7:0] cur_val = {main_osc_stop_q, 1'b0, clock_source_status_q, clock_source_select_q, 1'b0,
                          cpu_divider_sel_q};
    // Bit write merges one bit into the current value
    wire [7:0] bit_val = (cur_val & ~(8'h01 << BUS.bit_idx)) | ({7'h00, BUS.bit_val} << BUS.bit_idx);
    wire [7:0] new_val = byte_wr ? BUS.wdata : bit_val;
    wire any_wr = byte_wr | bit_wr;
    wire [2:0] new_div = new_val[CCS_DIV_LSB +: CCS_DIV_W];
    // Prohibited codes above 100 leave the divider unchanged
    wire new_div_ok = new_div <= CCS_DIV_MAX;
    wire [2:0] nxt_div = new_div_ok ? new_div : cpu_divider_sel_q;

    wire sub_tick = sub_cnt_q == 16'(SUB_DIV - 1);
    wire main_tick = osc_run_q & main_ready_q;
    wire main_cpu_tick = main_tick & ((main_div_q & div_mask(act_div_q)) == div_mask(act_div_q));
    wire sub_cpu_tick = sub_tick & sub_half_q;
    wire cpu_tick = clock_source_status_q ? sub_cpu_tick : main_cpu_tick;
    wire setting_diff = (clock_source_select_q != clock_source_status_q) | (cpu_divider_sel_q != act_div_q);
    // Stop mode halts main oscillator; bit 7 only once on subsystem clock
    wire osc_run_d = ~BUS.stop & ~(main_osc_stop_q & clock_source_status_q);

    // Register fields
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            main_osc_stop_q <= CCS_CTRL_REG_RESET[CCS_BIT_OSC_STOP];
            clock_source_select_q <= CCS_CTRL_REG_RESET[CCS_BIT_SRC_SEL];
            cpu_divider_sel_q <= CCS_DIV_RESET;
        end else if (any_wr) begin
            main_osc_stop_q <= new_val[CCS_BIT_OSC_STOP];
            clock_source_select_q <= new_val[CCS_BIT_SRC_SEL];
            cpu_divider_sel_q <= nxt_div;
        end
    end

    // Deferred switchover, counted on the old CPU clock
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sw_q <= CCS_SW_IDLE;
            sw_cnt_q <= 5'h00;
            clock_source_status_q <= 1'b0;
            act_div_q <= CCS_DIV_RESET;
        end else begin
            case (sw_q)
                CCS_SW_IDLE: begin
                    if (setting_diff) begin
                        sw_q <= CCS_SW_WAIT;
                        sw_cnt_q <= 5'(SWITCH_TICKS);
                    end
                end
                CCS_SW_WAIT: begin
                    if (any_wr) begin
                        sw_cnt_q <= 5'(SWITCH_TICKS);
                    end else if (cpu_tick && sw_cnt_q <= 5'h01) begin
                        clock_source_status_q <= clock_source_select_q;
                        act_div_q <= cpu_divider_sel_q;
                        sw_q <= CCS_SW_IDLE;
                    end else if (cpu_tick) begin
                        sw_cnt_q <= sw_cnt_q - 5'h01;
                    end
                end
                default: sw_q <= CCS_SW_IDLE;
            endcase
        end
    end

    // Oscillator control and stabilisation wait
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            osc_run_q <= 1'b0;
            stab_cnt_q <= 18'h0_0000;
            main_ready_q <= 1'b0;
            cpu_run_q <= 1'b0;
        end else begin
            osc_run_q <= osc_run_d;
            if (!osc_run_q) begin
                stab_cnt_q <= 18'h0_0000;
                main_ready_q <= 1'b0;
            end else if (!main_ready_q) begin
                stab_cnt_q <= stab_cnt_q + 18'h0_0001;
                main_ready_q <= stab_cnt_q == 18'(STAB_CYCLES - 1);
            end
            if (main_ready_q) begin
                cpu_run_q <= 1'b1;
            end
        end
    end

    // Free-running subsystem divider; no control input reaches it
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sub_cnt_q <= 16'h0000;
            sub_half_q <= 1'b0;
        end else begin
            sub_cnt_q <= sub_tick ? 16'h0000 : sub_cnt_q + 16'h0001;
            if (sub_tick) begin
                sub_half_q <= ~sub_half_q;
            end
        end
    end

    // Main clock prescaler
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            main_div_q <= 4'h0;
        end else if (main_tick) begin
            main_div_q <= main_div_q + 4'h1;
        end
    end

    // Read data stands in the cycle after the strobe
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 8'h00;
        end else if (BUS.rd) begin
            rdata_q <= hit ? cur_val : 8'h00;
        end
    end

    wire cpu_en = cpu_tick & cpu_run_q & ~BUS.halt & ~BUS.stop;
    assign BUS.rdata = rdata_q;
    assign BUS.cpu_run = cpu_run_q;
    assign BUS.cpu_clk_en = cpu_en;
    assign MAIN_OSC_RUN_O = osc_run_q;
    assign MAIN_CLK_EN_O = main_tick;
    assign SUB_CLK_EN_O = sub_tick;
    assign CPU_CLK_EN_O = cpu_en;
    assign WDT_EN_O = cpu_en & ~clock_source_status_q;
    assign CLK_SRC_SUB_O = clock_source_status_q;
endmodule : ccs_clock_gen

/* hw/ccs_cpu_ctrl.sv */
`timescale 1ns/100ps
module ccs_cpu_ctrl (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Command port
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Clock generator side
    ccs_if.host BUS
);
    import ccs_pkg::*;

    logic [3:0] mode_q;
    logic [7:0] shadow_q;
    logic [7:0] own_q;
    logic own_sel_q;

    wire ext_main = mode_q[CCS_MODE_EXT_MAIN];
    wire can_ext = mode_q[CCS_MODE_CAN_EXT];
    wire on_sub = shadow_q[CCS_BIT_SRC_STAT];
    wire byte_cmd = WR_I & (ADDR_I == CCS_H_REG_WR);
    wire bit_cmd = WR_I & (ADDR_I == CCS_H_BIT_WR);
    wire [2:0] b_idx = WDATA_I[2:0];
    // Bit writes to bits 3, 5, 6 dropped; bit 7 and bit 4 gated
    wire bit_ok = (b_idx != 3'h3) & (b_idx != 3'h5) & (b_idx != 3'h6)
                  & ~(b_idx == 3'h7 & WDATA_I[3] & ext_main)
                  & ~(b_idx == 3'h4 & WDATA_I[3] & can_ext);
    wire to_sub = WDATA_I[CCS_BIT_SRC_SEL] & ~shadow_q[CCS_BIT_SRC_SEL];
    wire [2:0] div_w = to_sub ? shadow_q[2:0] : WDATA_I[2:0];
    wire osc_stop_w = WDATA_I[CCS_BIT_OSC_STOP] & ~ext_main;
    wire src_sel_w = WDATA_I[CCS_BIT_SRC_SEL] & ~can_ext;
    wire [7:0] byte_w = {osc_stop_w, 1'b0, 1'b0, src_sel_w, 1'b0, div_w};
    wire stop_ok = mode_q[CCS_MODE_STOP] & ~on_sub & ~ext_main;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_q <= CCS_MODE_RESET;
            shadow_q <= CCS_CTRL_REG_RESET;
        end else begin
            if (WR_I && ADDR_I == CCS_H_MODE) begin
                mode_q <= WDATA_I[3:0];
            end
            if (byte_cmd) begin
                shadow_q <= byte_w;
            end else if (bit_cmd && bit_ok) begin
                shadow_q[b_idx] <= WDATA_I[3];
            end
        end
    end

    // Own status answers one cycle later, like the device
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            own_q <= 8'h00;
            own_sel_q <= 1'b0;
        end else begin
            own_sel_q <= RD_I & (ADDR_I != CCS_H_REG_RD);
            if (RD_I) begin
                own_q <= (ADDR_I == CCS_H_STATUS) ? {5'h00, stop_ok, BUS.halt, BUS.cpu_run} :
                         (ADDR_I == CCS_H_MODE) ? {4'h0, mode_q} : 8'h00;
            end
        end
    end

    assign BUS.addr = CCS_CTRL_REG_ADDR;
    assign BUS.wr_byte = byte_cmd;
    assign BUS.wr_bit = bit_cmd & bit_ok;
    assign BUS.wdata = byte_w;
    assign BUS.bit_idx = b_idx;
    assign BUS.bit_val = WDATA_I[3];
    assign BUS.rd = RD_I & (ADDR_I == CCS_H_REG_RD);
    assign BUS.halt = mode_q[CCS_MODE_HALT];
    assign BUS.stop = stop_ok;
    assign RDATA_O = own_sel_q ? own_q : BUS.rdata;
endmodule : ccs_cpu_ctrl

/* testbench/ccs_sva.sv */
`timescale 1ns/100ps
module ccs_sva #(
    parameter int STAB_CYCLES = 16
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Device bus
    input wire logic wr_byte,
    input wire logic wr_bit,
    input wire logic rd,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [2:0] bit_idx,
    input wire logic bit_val,
    input wire logic [7:0] rdata,
    input wire logic stop,
    input wire logic cpu_run,
    // Clock outputs
    input wire logic MAIN_OSC_RUN_O,
    input wire logic SUB_CLK_EN_O,
    input wire logic WDT_EN_O,
    input wire logic CLK_SRC_SUB_O
);
    import ccs_pkg::*;
    logic wrote_q;
    int osc_cnt_q;
    // No reset here: set only once the design's registers have taken reset
    logic rst_seen_q;
    always_ff @(posedge SYS_CLK_I) begin
        rst_seen_q <= RST_I;
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wrote_q <= 1'b0;
            osc_cnt_q <= 0;
        end else begin
            wrote_q <= wrote_q | wr_byte | wr_bit;
            osc_cnt_q <= MAIN_OSC_RUN_O ? osc_cnt_q + 1 : 0;
        end
    end
    sequence s_rd;
        rd && addr == CCS_CTRL_REG_ADDR;
    endsequence
    sequence s_byte;
        wr_byte && addr == CCS_CTRL_REG_ADDR && wdata[2:0] <= CCS_DIV_MAX;
    endsequence
    sequence s_bit7;
        wr_bit && addr == CCS_CTRL_REG_ADDR && bit_idx == 3'h7;
    endsequence
    a_reset_value: assert property (
        rd && addr == CCS_CTRL_REG_ADDR && !wrote_q |=> rdata == CCS_CTRL_REG_RESET) else $error("reset value wrong");
    a_rsvd_zero: assert property (
        s_rd |=> !rdata[3] && !rdata[6]) else $error("reserved bit set");
    a_byte_readback: assert property (
        s_byte ##1 s_rd |=> rdata[2:0] == $past(wdata[2:0], 2) && rdata[4] == $past(wdata[4], 2))
        else $error("byte write lost");
    a_bit7_readback: assert property (
        s_bit7 ##1 s_rd |=> rdata[7] == $past(bit_val, 2)) else $error("bit write lost");
    a_osc_held: assert property (
        $fell(MAIN_OSC_RUN_O) |-> $past(CLK_SRC_SUB_O) || $past(stop)) else $error("main osc stopped early");
    // Checked during reset itself, so no disable here
    a_osc_rst_off: assert property (disable iff (1'b0)
        RST_I && rst_seen_q |-> !MAIN_OSC_RUN_O && !cpu_run) else $error("main osc runs in reset");
    a_wdt_on_sub: assert property (
        CLK_SRC_SUB_O && $past(CLK_SRC_SUB_O) |-> !WDT_EN_O) else $error("watchdog ticks on sub clock");
    // Spacing written for the bench's SUB_DIV of 4
    a_sub_free: assert property (
        SUB_CLK_EN_O |=> !SUB_CLK_EN_O [*3] ##1 SUB_CLK_EN_O) else $error("sub clock gap wrong");
    a_stab_wait: assert property (
        $rose(cpu_run) |-> osc_cnt_q >= STAB_CYCLES) else $error("cpu started before stable");
    a_wr_clean: assert property (
        (wr_byte |-> !wdata[3] && !wdata[5]) and (wr_bit |-> !(bit_idx inside {3'h3, 3'h5, 3'h6})))
        else $error("zero bit written as one");
endmodule : ccs_sva

/* testbench/cpu_clock_select_control_tb.sv */
`timescale 1ns/100ps
module cpu_clock_select_control_tb;
    import ccs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic [7:0] v;
    logic osc_run, cpu_en, wdt_en, src_sub, sub_en;
    int num_errors = 0;
    int n_compared = 0;
    ccs_if ccs_if_i ();
    ccs_clock_gen #(.STAB_CYCLES(16), .SUB_DIV(4), .SWITCH_TICKS(16)) ccs_clock_gen_i (
        .SYS_CLK_I(sys_clk), .RST_I(rst), .BUS(ccs_if_i), .MAIN_OSC_RUN_O(osc_run), .MAIN_CLK_EN_O(),
        .SUB_CLK_EN_O(sub_en), .CPU_CLK_EN_O(cpu_en), .WDT_EN_O(wdt_en), .CLK_SRC_SUB_O(src_sub));
    ccs_cpu_ctrl ccs_cpu_ctrl_i (.SYS_CLK_I(sys_clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd_s), .RDATA_O(rdata), .BUS(ccs_if_i));
    ccs_sva #(.STAB_CYCLES(16)) ccs_sva_i (.SYS_CLK_I(sys_clk), .RST_I(rst),
        .wr_byte(ccs_if_i.wr_byte), .wr_bit(ccs_if_i.wr_bit), .rd(ccs_if_i.rd), .addr(ccs_if_i.addr),
        .wdata(ccs_if_i.wdata), .bit_idx(ccs_if_i.bit_idx), .bit_val(ccs_if_i.bit_val),
        .rdata(ccs_if_i.rdata), .stop(ccs_if_i.stop), .cpu_run(ccs_if_i.cpu_run),
        .MAIN_OSC_RUN_O(osc_run), .SUB_CLK_EN_O(sub_en), .WDT_EN_O(wdt_en), .CLK_SRC_SUB_O(src_sub));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    // Holds the strobe high for the closing edge and drops it after: callers space writes by a cycle
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
        @(posedge sys_clk);
    endtask : rd_reg
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // 64 cycles is a whole number of periods for every rate, so phase does not matter
    task automatic ticks(input logic [7:0] e_cpu, input logic [7:0] e_wdt);
        logic [7:0] nc;
        logic [7:0] nw;
        nc = 8'h00;
        nw = 8'h00;
        repeat (64) begin
            @(negedge sys_clk);
            nc = nc + {7'h00, cpu_en === 1'b1};
            nw = nw + {7'h00, wdt_en === 1'b1};
        end
        @(posedge sys_clk);
        chk("cpu_ticks", e_cpu, nc);
        chk("wdt_ticks", e_wdt, nw);
    endtask : ticks
    task automatic wrap_up();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        wt(20000);
        num_errors++;
        $display("ERROR watchdog expected end seen hang");
        wrap_up();
    end
    initial begin
        wt(20);
        rst <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            rd_reg(4'h4, v);
            if (v[0] === 1'b1) break;
        end
        chk("cpu_run", 8'h01, {7'h00, v[0]});
        rd_reg(4'h3, v);
        chk("reset_reg", 8'h04, v);
        for (int d = 0; d < 5; d++) begin
            wr_reg(4'h0, 8'(d));
            rd_reg(4'h3, v);
            chk("divider", 8'(d), v);
            wt(300);
            ticks(8'(64 >> d), 8'(64 >> d));
        end
        wr_reg(4'h1, 8'h0F);
        rd_reg(4'h3, v);
        chk("stop_bit", 8'h84, v);
        wt(20);
        chk("osc_kept", 8'h01, {7'h00, osc_run});
        wr_reg(4'h0, 8'h97);
        rd_reg(4'h3, v);
        chk("to_sub", 8'h94, v);
        wt(300);
        rd_reg(4'h3, v);
        chk("on_sub", 8'hB4, v);
        chk("osc_off", 8'h00, {7'h00, osc_run});
        ticks(8'h08, 8'h00);
        wr_reg(4'h0, 8'h90);
        wt(150);
        ticks(8'h08, 8'h00);
        wr_reg(4'h0, 8'h03);
        wt(400);
        rd_reg(4'h3, v);
        chk("to_main", 8'h03, v);
        chk("osc_on", 8'h01, {7'h00, osc_run});
        ticks(8'h08, 8'h08);
        wr_reg(4'h2, 8'h04);
        wt(4);
        ticks(8'h00, 8'h00);
        wr_reg(4'h2, 8'h08);
        wt(1);
        rd_reg(4'h4, v);
        chk("stop_ok", 8'h05, v);
        wt(4);
        chk("osc_stop", 8'h00, {7'h00, osc_run});
        wr_reg(4'h2, 8'h02);
        wt(1);
        wr_reg(4'h0, 8'h13);
        rd_reg(4'h3, v);
        chk("can_ext", 8'h03, v);
        wr_reg(4'h2, 8'h01);
        wt(1);
        wr_reg(4'h1, 8'h0F);
        rd_reg(4'h3, v);
        chk("ext_main", 8'h03, v);
        wrap_up();
    end
endmodule : cpu_clock_select_control_tb
